// ==== pkg/rt_circ2_pkg.sv ====
package rt_circ2_pkg;
  // ==========================================================================
  // bus and word widths
  localparam int          APB_AW          = 12;
  localparam int          WORD_W          = 16;
  localparam int          PTR_W           = 16;
  localparam int          WC_W            = 5;
  localparam int          CNT_W           = 6;
  localparam logic [5:0]  MAX_WORDS       = 6'h20;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [9:0]  IDX_PEND        = 10'h009;
  localparam logic [9:0]  IDX_INT_EN      = 10'h012;
  localparam logic [9:0]  IDX_RT_CFG      = 10'h017;
  localparam logic [9:0]  IDX_EXT_CFG     = 10'h04D;
  localparam logic [9:0]  IDX_DESC_BASE   = 10'h060;
  localparam logic [9:0]  IDX_STATUS      = 10'h061;

  // ==========================================================================
  // register fields
  localparam int          IRQ_BIT         = 0;
  localparam int          BSEP_BIT        = 0;
  localparam int          BFLAG_EN_BIT    = 3;
  localparam int          INFO_BROADCAST_FLAG_BIT  = 9;

  // ==========================================================================
  // descriptor control word fields
  localparam int          CW_BLOCK_DONE_IRQ_ENABLE_BIT    = 8;
  localparam int          CW_PINGPONG_SELECT_BIT     = 2;
  localparam int          CW_CIR2_BIT     = 1;
  localparam int          CW_CODE_LSB     = 4;
  localparam int          CW_CODE_MSB     = 7;

  // ==========================================================================
  // descriptor word offsets from N
  localparam logic [1:0]  DW_CTRL         = 2'h0;
  localparam logic [1:0]  DW_START        = 2'h1;
  localparam logic [1:0]  DW_CUR          = 2'h2;
  localparam logic [1:0]  DW_INFO         = 2'h3;

  // ==========================================================================
  // reset values
  localparam logic [15:0] RST_WORD        = 16'h0000;
  localparam logic [15:0] RST_DESC_BASE   = 16'h0400;
endpackage

// ==== hdl/rt_circular_buffer_mode2.sv ====
// Operation
// - low info pointer bits count completed messages
// - 128 messages need 8 zeros; step two
// - full count: increment once, low bits all ones
// - full count restores info base, start to current
// - descriptor chosen by T/R and subaddress only
// - control bits 7:4 encode message count
// - receive words stored from current data pointer
// - receive: info and tag first, then pointers
// - not full: pointers move to next locations
// - last message: both pointers back to base
// - block done interrupt needs both enables set
// - transmit words read from current data pointer
// - transmit: info, tag, pointers as receive
// - broadcast receive data shares the same buffer
// - extended config bit 3 adds broadcast flag
// - broadcast transmit: no bus, pointers unchanged
// - next transmit overwrites broadcast info words
// - completion by message count, not buffer fill
// - error, busy, illegal: info written, no advance
// - mode: ping-pong select zero, circ2 select one
// - descriptor N..N+3: ctrl, start, current, info
//
// Implementation choices: register access over APB and the register offsets.
module rt_circular_buffer_mode2 #(
  parameter int PTR_W = rt_circ2_pkg::PTR_W
) (
  // clock and reset
  input  wire logic                            REF_CLK_I,
  input  wire logic                            RST_N_I,
  // apb slave
  input  wire logic                            PSEL_I,
  input  wire logic                            PENABLE_I,
  input  wire logic                            PWRITE_I,
  input  wire logic [rt_circ2_pkg::APB_AW-1:0] PADDR_I,
  input  wire logic [31:0]                     PWDATA_I,
  output logic      [31:0]                     PRDATA_O,
  output logic                                 PREADY_O,
  output logic                                 PSLVERR_O,
  // command from protocol core
  input  wire logic                            CMD_START_I,
  input  wire logic [15:0]                     CMD_WORD_I,
  input  wire logic                            CMD_BROADCAST_FLAG_I,
  output logic                                 CMD_DONE_O,
  // receive data words
  input  wire logic                            RX_VALID_I,
  input  wire logic [rt_circ2_pkg::WORD_W-1:0] RX_WORD_I,
  output logic                                 RX_READY_O,
  // transmit data words
  output logic                                 TX_VALID_O,
  output logic      [rt_circ2_pkg::WORD_W-1:0] TX_WORD_O,
  input  wire logic                            TX_READY_I,
  // message end with status
  input  wire logic                            MSG_END_I,
  input  wire logic                            MSG_ERR_I,
  input  wire logic [rt_circ2_pkg::WORD_W-1:0] MSG_INFO_I,
  input  wire logic [rt_circ2_pkg::WORD_W-1:0] MSG_TAG_I,
  output logic                                 MSG_END_READY_O,
  // ram master
  output logic                                 MEM_REQ_O,
  output logic                                 MEM_WE_O,
  output logic      [PTR_W-1:0]                MEM_ADDR_O,
  output logic      [rt_circ2_pkg::WORD_W-1:0] MEM_WDATA_O,
  input  wire logic [rt_circ2_pkg::WORD_W-1:0] MEM_RDATA_I,
  input  wire logic                            MEM_ACK_I,
  // interrupt
  output logic                                 INT_N_O
);

  typedef enum logic [10:0] {
    S_IDLE  = 11'b000_0000_0001,
    S_FETCH = 11'b000_0000_0010,
    S_RX    = 11'b000_0000_0100,
    S_RXWR  = 11'b000_0000_1000,
    S_TXRD  = 11'b000_0001_0000,
    S_TXOUT = 11'b000_0010_0000,
    S_END   = 11'b000_0100_0000,
    S_INFO  = 11'b000_1000_0000,
    S_TAG   = 11'b001_0000_0000,
    S_CA    = 11'b010_0000_0000,
    S_MSG_INFO_PTR  = 11'b100_0000_0000
  } state_t;

  function automatic logic [PTR_W-1:0] low_mask(input logic [3:0] code);
    low_mask = ~({PTR_W{1'b1}} << code);
  endfunction

  // ==========================================================================
  // apb registers
  logic        int_en_ff,    nxt_int_en;
  logic        pend_ff,      nxt_pend;
  logic [15:0] rt_cfg_ff,    nxt_rt_cfg;
  logic [15:0] ext_cfg_ff,   nxt_ext_cfg;
  logic [15:0] desc_base_ff, nxt_desc_base;
  logic [31:0] prdata_ff,    nxt_prdata;
  logic        pslverr_ff,   nxt_pslverr;
  logic        block_done;
  logic [9:0]  reg_idx;
  logic        wr_acc;
  logic        rd_setup;
  logic        mapped;

  assign reg_idx  = PADDR_I[rt_circ2_pkg::APB_AW-1:2];
  assign wr_acc   = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;

  // ==========================================================================
  // message engine state
  state_t           state_ff,   nxt_state;
  logic [15:0]      cmd_ff,     nxt_cmd;
  logic             broadcast_flag_ff,   nxt_broadcast_flag;
  logic [1:0]       idx_ff,     nxt_idx;
  logic [15:0]      ctrl_ff,    nxt_ctrl;
  logic [PTR_W-1:0] sa_ff,      nxt_sa;
  logic [PTR_W-1:0] ca_ff,      nxt_ca;
  logic [PTR_W-1:0] msg_info_ptr_ff,    nxt_msg_info_ptr;
  logic [5:0]       cnt_ff,     nxt_cnt;
  logic             err_ff,     nxt_err;
  logic [15:0]      tag_ff,     nxt_tag;
  logic             req_ff,     nxt_req;
  logic             we_ff,      nxt_we;
  logic [PTR_W-1:0] addr_ff,    nxt_addr;
  logic [15:0]      wdata_ff,   nxt_wdata;
  logic             txv_ff,     nxt_txv;
  logic [15:0]      txw_ff,     nxt_txw;

  logic [PTR_W-1:0] desc_n;
  logic [5:0]       words;
  logic [PTR_W-1:0] mask;
  logic [PTR_W-1:0] msg_info_ptr_inc;
  logic             full;
  logic             mode2;
  logic             tx_b31;
  logic [PTR_W-1:0] upd_ca;
  logic [PTR_W-1:0] upd_msg_info_ptr;
  logic [15:0]      info_word;

  assign desc_n    = PTR_W'(desc_base_ff) + PTR_W'({cmd_ff[10], cmd_ff[9:5], 2'b00});
  assign words     = (cmd_ff[4:0] == 5'h00) ? rt_circ2_pkg::MAX_WORDS : {1'b0, cmd_ff[4:0]};
  assign mask      = low_mask(ctrl_ff[rt_circ2_pkg::CW_CODE_MSB:rt_circ2_pkg::CW_CODE_LSB]);
  assign msg_info_ptr_inc  = msg_info_ptr_ff + PTR_W'(1);
  assign full      = ((msg_info_ptr_inc & mask) == mask);
  assign mode2     = ~ctrl_ff[rt_circ2_pkg::CW_PINGPONG_SELECT_BIT] & ctrl_ff[rt_circ2_pkg::CW_CIR2_BIT];
  assign tx_b31    = cmd_ff[10] & broadcast_flag_ff;
  assign upd_ca    = full ? sa_ff : ca_ff + PTR_W'(words);
  assign upd_msg_info_ptr  = full ? (msg_info_ptr_ff & ~mask) : msg_info_ptr_ff + PTR_W'(2);
  assign block_done = (state_ff == S_MSG_INFO_PTR) & MEM_ACK_I & full & ctrl_ff[rt_circ2_pkg::CW_BLOCK_DONE_IRQ_ENABLE_BIT];

  // ==========================================================================
  // apb next state
  always_comb begin
    nxt_int_en    = int_en_ff;
    nxt_rt_cfg    = rt_cfg_ff;
    nxt_ext_cfg   = ext_cfg_ff;
    nxt_desc_base = desc_base_ff;
    nxt_prdata    = prdata_ff;
    nxt_pslverr   = 1'b0;
    nxt_pend      = pend_ff;
    mapped        = 1'b1;
    unique case (reg_idx)
      rt_circ2_pkg::IDX_PEND,
      rt_circ2_pkg::IDX_INT_EN,
      rt_circ2_pkg::IDX_RT_CFG,
      rt_circ2_pkg::IDX_EXT_CFG,
      rt_circ2_pkg::IDX_DESC_BASE,
      rt_circ2_pkg::IDX_STATUS: mapped = (PADDR_I[1:0] == 2'b00);
      default:                  mapped = 1'b0;
    endcase
    if (PSEL_I & ~PENABLE_I) begin
      nxt_pslverr = ~mapped;
    end
    if (rd_setup) begin
      unique case (reg_idx)
        rt_circ2_pkg::IDX_PEND:      nxt_prdata = {31'h0, pend_ff};
        rt_circ2_pkg::IDX_INT_EN:    nxt_prdata = {31'h0, int_en_ff};
        rt_circ2_pkg::IDX_RT_CFG:    nxt_prdata = {16'h0, rt_cfg_ff};
        rt_circ2_pkg::IDX_EXT_CFG:   nxt_prdata = {16'h0, ext_cfg_ff};
        rt_circ2_pkg::IDX_DESC_BASE: nxt_prdata = {16'h0, desc_base_ff};
        rt_circ2_pkg::IDX_STATUS:    nxt_prdata = {5'h0, state_ff, 16'(msg_info_ptr_ff)};
        default:                     nxt_prdata = 32'h0000_0000;
      endcase
      if (!mapped) begin
        nxt_prdata = 32'h0000_0000;
      end
    end
    if (wr_acc & mapped) begin
      unique case (reg_idx)
        rt_circ2_pkg::IDX_PEND:      nxt_pend = pend_ff & ~PWDATA_I[rt_circ2_pkg::IRQ_BIT];
        rt_circ2_pkg::IDX_INT_EN:    nxt_int_en = PWDATA_I[rt_circ2_pkg::IRQ_BIT];
        rt_circ2_pkg::IDX_RT_CFG:    nxt_rt_cfg = PWDATA_I[15:0];
        rt_circ2_pkg::IDX_EXT_CFG:   nxt_ext_cfg = PWDATA_I[15:0];
        rt_circ2_pkg::IDX_DESC_BASE: nxt_desc_base = PWDATA_I[15:0];
        default:                     nxt_pend = pend_ff;
      endcase
    end
    // set wins over a clear in the same cycle
    if (block_done & int_en_ff) begin
      nxt_pend = 1'b1;
    end
  end

  // broadcast separation option is kept for software only; data is never split
  assign info_word = MSG_INFO_I |
                     (16'(ext_cfg_ff[rt_circ2_pkg::BFLAG_EN_BIT] & broadcast_flag_ff) << rt_circ2_pkg::INFO_BROADCAST_FLAG_BIT);

  // ==========================================================================
  // message engine next state
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd   = cmd_ff;
    nxt_broadcast_flag = broadcast_flag_ff;
    nxt_idx   = idx_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_sa    = sa_ff;
    nxt_ca    = ca_ff;
    nxt_msg_info_ptr  = msg_info_ptr_ff;
    nxt_cnt   = cnt_ff;
    nxt_err   = err_ff;
    nxt_tag   = tag_ff;
    nxt_req   = req_ff;
    nxt_we    = we_ff;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_txv   = txv_ff;
    nxt_txw   = txw_ff;
    CMD_DONE_O = 1'b0;
    // a message end is accepted only where the engine can log it
    if (MSG_END_READY_O & MSG_END_I) begin
      nxt_err   = MSG_ERR_I;
      nxt_tag   = MSG_TAG_I;
      nxt_txv   = 1'b0;
      nxt_req   = 1'b1;
      nxt_we    = 1'b1;
      nxt_addr  = msg_info_ptr_ff;
      nxt_wdata = info_word;
      nxt_state = S_INFO;
    end else begin
      unique case (state_ff)
        S_IDLE: begin
          if (CMD_START_I) begin
            nxt_cmd   = CMD_WORD_I;
            nxt_broadcast_flag = CMD_BROADCAST_FLAG_I;
            nxt_idx   = rt_circ2_pkg::DW_CTRL;
            nxt_cnt   = 6'h00;
            nxt_state = S_FETCH;
          end
        end
        S_FETCH: begin
          nxt_req  = 1'b1;
          nxt_we   = 1'b0;
          nxt_addr = desc_n + PTR_W'(idx_ff);
          if (req_ff & MEM_ACK_I) begin
            nxt_req = 1'b0;
            nxt_idx = idx_ff + 2'h1;
            unique case (idx_ff)
              rt_circ2_pkg::DW_CTRL:  nxt_ctrl = MEM_RDATA_I;
              rt_circ2_pkg::DW_START: nxt_sa   = PTR_W'(MEM_RDATA_I);
              rt_circ2_pkg::DW_CUR:   nxt_ca   = PTR_W'(MEM_RDATA_I);
              rt_circ2_pkg::DW_INFO:  nxt_msg_info_ptr = PTR_W'(MEM_RDATA_I);
            endcase
            if (idx_ff == rt_circ2_pkg::DW_INFO) begin
              if (!mode2) begin
                CMD_DONE_O = 1'b1;
                nxt_state  = S_IDLE;
              end else if (cmd_ff[10] & !broadcast_flag_ff) begin
                nxt_req   = 1'b1;
                nxt_addr  = ca_ff;
                nxt_state = S_TXRD;
              end else begin
                nxt_state = cmd_ff[10] ? S_END : S_RX;
              end
            end
          end
        end
        S_RX: begin
          if (RX_VALID_I) begin
            nxt_req   = 1'b1;
            nxt_we    = 1'b1;
            nxt_addr  = ca_ff + PTR_W'(cnt_ff);
            nxt_wdata = RX_WORD_I;
            nxt_state = S_RXWR;
          end
        end
        S_RXWR: begin
          if (MEM_ACK_I) begin
            nxt_req   = 1'b0;
            nxt_cnt   = cnt_ff + 6'h01;
            nxt_state = (cnt_ff + 6'h01 == words) ? S_END : S_RX;
          end
        end
        S_TXRD: begin
          if (MEM_ACK_I) begin
            nxt_req   = 1'b0;
            nxt_txw   = MEM_RDATA_I;
            nxt_txv   = 1'b1;
            nxt_state = S_TXOUT;
          end
        end
        S_TXOUT: begin
          if (TX_READY_I) begin
            nxt_txv = 1'b0;
            nxt_cnt = cnt_ff + 6'h01;
            if (cnt_ff + 6'h01 == words) begin
              nxt_state = S_END;
            end else begin
              nxt_req   = 1'b1;
              nxt_we    = 1'b0;
              nxt_addr  = ca_ff + PTR_W'(cnt_ff + 6'h01);
              nxt_state = S_TXRD;
            end
          end
        end
        S_END: begin
          nxt_state = S_END;
        end
        S_INFO: begin
          if (MEM_ACK_I) begin
            nxt_addr  = msg_info_ptr_inc;
            nxt_wdata = tag_ff;
            nxt_state = S_TAG;
          end
        end
        S_TAG: begin
          if (MEM_ACK_I) begin
            if (err_ff | tx_b31) begin
              nxt_req    = 1'b0;
              CMD_DONE_O = 1'b1;
              nxt_state  = S_IDLE;
            end else begin
              nxt_addr  = desc_n + PTR_W'(rt_circ2_pkg::DW_CUR);
              nxt_wdata = 16'(upd_ca);
              nxt_state = S_CA;
            end
          end
        end
        S_CA: begin
          if (MEM_ACK_I) begin
            nxt_addr  = desc_n + PTR_W'(rt_circ2_pkg::DW_INFO);
            nxt_wdata = 16'(upd_msg_info_ptr);
            nxt_state = S_MSG_INFO_PTR;
          end
        end
        S_MSG_INFO_PTR: begin
          if (MEM_ACK_I) begin
            nxt_req    = 1'b0;
            nxt_we     = 1'b0;
            nxt_ca     = upd_ca;
            nxt_msg_info_ptr   = upd_msg_info_ptr;
            CMD_DONE_O = 1'b1;
            nxt_state  = S_IDLE;
          end
        end
        default: nxt_state = S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      int_en_ff    <= 1'b0;
      pend_ff      <= 1'b0;
      rt_cfg_ff    <= rt_circ2_pkg::RST_WORD;
      ext_cfg_ff   <= rt_circ2_pkg::RST_WORD;
      desc_base_ff <= rt_circ2_pkg::RST_DESC_BASE;
      prdata_ff    <= 32'h0000_0000;
      pslverr_ff   <= 1'b0;
      state_ff     <= S_IDLE;
      cmd_ff       <= rt_circ2_pkg::RST_WORD;
      broadcast_flag_ff     <= 1'b0;
      idx_ff       <= 2'h0;
      ctrl_ff      <= rt_circ2_pkg::RST_WORD;
      sa_ff        <= '0;
      ca_ff        <= '0;
      msg_info_ptr_ff      <= '0;
      cnt_ff       <= 6'h00;
      err_ff       <= 1'b0;
      tag_ff       <= rt_circ2_pkg::RST_WORD;
      req_ff       <= 1'b0;
      we_ff        <= 1'b0;
      addr_ff      <= '0;
      wdata_ff     <= rt_circ2_pkg::RST_WORD;
      txv_ff       <= 1'b0;
      txw_ff       <= rt_circ2_pkg::RST_WORD;
    end else begin
      int_en_ff    <= nxt_int_en;
      pend_ff      <= nxt_pend;
      rt_cfg_ff    <= nxt_rt_cfg;
      ext_cfg_ff   <= nxt_ext_cfg;
      desc_base_ff <= nxt_desc_base;
      prdata_ff    <= nxt_prdata;
      pslverr_ff   <= nxt_pslverr;
      state_ff     <= nxt_state;
      cmd_ff       <= nxt_cmd;
      broadcast_flag_ff     <= nxt_broadcast_flag;
      idx_ff       <= nxt_idx;
      ctrl_ff      <= nxt_ctrl;
      sa_ff        <= nxt_sa;
      ca_ff        <= nxt_ca;
      msg_info_ptr_ff      <= nxt_msg_info_ptr;
      cnt_ff       <= nxt_cnt;
      err_ff       <= nxt_err;
      tag_ff       <= nxt_tag;
      req_ff       <= nxt_req;
      we_ff        <= nxt_we;
      addr_ff      <= nxt_addr;
      wdata_ff     <= nxt_wdata;
      txv_ff       <= nxt_txv;
      txw_ff       <= nxt_txw;
    end
  end

  // ==========================================================================
  // outputs
  assign PRDATA_O        = prdata_ff;
  assign PREADY_O        = 1'b1;
  assign PSLVERR_O       = pslverr_ff & PSEL_I & PENABLE_I;
  assign RX_READY_O      = (state_ff == S_RX);
  assign TX_VALID_O      = txv_ff;
  assign TX_WORD_O       = txw_ff;
  assign MSG_END_READY_O = (state_ff == S_RX) | (state_ff == S_TXOUT) | (state_ff == S_END);
  assign MEM_REQ_O       = req_ff;
  assign MEM_WE_O        = we_ff;
  assign MEM_ADDR_O      = addr_ff;
  assign MEM_WDATA_O     = wdata_ff;
  assign INT_N_O         = ~(pend_ff & int_en_ff);

endmodule // rt_circular_buffer_mode2

// ==== test/rt_circ2_properties.sv ====
module rt_circ2_properties #(
  parameter int PTR_W = 16
) (
  // clock and reset
  input wire logic             REF_CLK_I,
  input wire logic             RST_N_I,
  // apb
  input wire logic             PSEL_I,
  input wire logic             PENABLE_I,
  input wire logic             PWRITE_I,
  input wire logic [11:0]      PADDR_I,
  input wire logic [31:0]      PRDATA_O,
  input wire logic             PREADY_O,
  input wire logic             PSLVERR_O,
  // engine
  input wire logic             CMD_START_I,
  input wire logic             CMD_DONE_O,
  input wire logic             RX_READY_O,
  input wire logic             TX_VALID_O,
  input wire logic [15:0]      TX_WORD_O,
  input wire logic             TX_READY_I,
  input wire logic             MEM_REQ_O,
  input wire logic             MEM_WE_O,
  input wire logic [PTR_W-1:0] MEM_ADDR_O,
  input wire logic             MEM_ACK_I,
  input wire logic             INT_N_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // properties
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  apb_ready_a: assert property (PREADY_O) else $error("pready low");
  bad_align_a: assert property (PSEL_I && PENABLE_I && PADDR_I[1:0] != 2'h0 |-> PSLVERR_O
    && (PWRITE_I || PRDATA_O == 32'h0000_0000)) else $error("misaligned not refused");
  err_phase_a: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I) else $error("stray slverr");
  done_pulse_a: assert property (CMD_DONE_O |=> !CMD_DONE_O) else $error("done too long");
  mem_hold_a: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O)
    && $stable(MEM_WE_O)) else $error("mem request dropped");
  tx_hold_a: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_WORD_O))
    else $error("tx word dropped");
  dir_excl_a: assert property (RX_READY_O |-> !TX_VALID_O) else $error("rx and tx at once");
  fetch_first_a: assert property (CMD_START_I && !MEM_REQ_O && !RX_READY_O && !TX_VALID_O
    |-> ##[1:4] (MEM_REQ_O && !MEM_WE_O)) else $error("no descriptor fetch");
  int_clear_a: assert property ($rose(INT_N_O) |-> $past(PSEL_I && PENABLE_I && PWRITE_I))
    else $error("int cleared without write");
  int_set_a: assert property ($fell(INT_N_O) |-> $past(MEM_REQ_O || CMD_DONE_O || PWRITE_I))
    else $error("int raised without cause");
  cover property (!INT_N_O);
  cover property (PSLVERR_O);
  cover property (TX_VALID_O && TX_READY_I);
  cover property (CMD_DONE_O);
endmodule // rt_circ2_properties

bind rt_circular_buffer_mode2 rt_circ2_properties #(.PTR_W(PTR_W)) chk_u (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .CMD_START_I(CMD_START_I), .CMD_DONE_O(CMD_DONE_O), .RX_READY_O(RX_READY_O), .TX_VALID_O(TX_VALID_O),
  .TX_WORD_O(TX_WORD_O), .TX_READY_I(TX_READY_I), .MEM_REQ_O(MEM_REQ_O), .MEM_WE_O(MEM_WE_O),
  .MEM_ADDR_O(MEM_ADDR_O), .MEM_ACK_I(MEM_ACK_I), .INT_N_O(INT_N_O));

// ==== test/ram_model.sv ====
module ram_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // memory port
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        slow_i,
  output logic      [15:0] rdata_o,
  output logic             ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_ff [0:65535];
  logic [15:0] rdata_ff;
  logic        ack_ff;
  logic [1:0]  wait_ff;
  assign rdata_o = rdata_ff;
  assign ack_o = ack_ff;
  // read data scrambles outside ack so stale data never looks valid
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_ff <= 1'b0;
      wait_ff <= 2'h0;
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= ~rdata_ff;
      ack_ff <= 1'b0;
      if (req_i && !ack_ff) begin
        if (wait_ff != 2'h0) wait_ff <= wait_ff - 2'h1;
        else begin
          ack_ff <= 1'b1;
          rdata_ff <= mem_ff[addr_i];
          wait_ff <= slow_i ? 2'h2 : 2'h0;
          if (we_i) mem_ff[addr_i] <= wdata_i;
        end
      end
    end
  end
endmodule // ram_model

// ==== test/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // signals
  logic        clk, rst_n, psel, pen, pwr, start, bc, rxv, txr, mend, merr, slow, e, full;
  logic        pready, pslv, done, rxr, txv, mer, mreq, mwe, ack, int_n, pend, ien, ext3;
  logic [11:0] paddr;
  logic [31:0] pwd, prd, r;
  logic [15:0] cmdw, rxw, txw, minfo, mtag, maddr, mwd, mrd;
  logic [15:0] cur [128], inf [128], sp [128];
  logic [31:0] wq [$];
  logic [15:0] tq [$];
  int          error_cnt, checks, k;
  rt_circular_buffer_mode2 dut_u (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(pslv),
    .CMD_START_I(start), .CMD_WORD_I(cmdw), .CMD_BROADCAST_FLAG_I(bc), .CMD_DONE_O(done),
    .RX_VALID_I(rxv), .RX_WORD_I(rxw), .RX_READY_O(rxr), .TX_VALID_O(txv), .TX_WORD_O(txw),
    .TX_READY_I(txr), .MSG_END_I(mend), .MSG_ERR_I(merr), .MSG_INFO_I(minfo), .MSG_TAG_I(mtag),
    .MSG_END_READY_O(mer), .MEM_REQ_O(mreq), .MEM_WE_O(mwe), .MEM_ADDR_O(maddr),
    .MEM_WDATA_O(mwd), .MEM_RDATA_I(mrd), .MEM_ACK_I(ack), .INT_N_O(int_n));
  ram_model ram_u (.clk_i(clk), .rst_n_i(rst_n), .req_i(mreq), .we_i(mwe), .addr_i(maddr),
    .wdata_i(mwd), .slow_i(slow), .rdata_o(mrd), .ack_o(ack));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========
  // tasks
  task chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task summarize;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prd;
    e = pslv;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task desc(input logic [6:0] x, input logic [15:0] c, s, m);
    ram_u.mem_ff[16'h0400 + {x, 2'b00}] = c;
    ram_u.mem_ff[16'h0401 + {x, 2'b00}] = s;
    ram_u.mem_ff[16'h0402 + {x, 2'b00}] = s;
    ram_u.mem_ff[16'h0403 + {x, 2'b00}] = m;
    cur[x] = s;
    sp[x] = s;
    inf[x] = m;
  endtask
  task msg(input logic tr, input logic [4:0] sa, wc, input logic b, er);
    logic [6:0]  x;
    logic [15:0] nd, ctl, mask, w, nc, ni;
    int          n;
    x = {tr, sa};
    nd = 16'h0400 + {x, 2'b00};
    ctl = ram_u.mem_ff[nd];
    n = (wc == 5'h00) ? 32 : int'(wc);
    mask = (16'h0001 << ctl[7:4]) - 16'h0001;
    start <= 1'b1;
    cmdw <= {5'h00, tr, sa, wc};
    bc <= b;
    @(posedge clk);
    start <= 1'b0;
    if (!ctl[2] && ctl[1]) begin
      for (int i = 0; i < n && !(b && tr); i++) begin
        if (!tr) begin
          w = 16'($urandom);
          wq.push_back({cur[x] + 16'(i), w});
          rxw <= w;
          rxv <= 1'b1;
          do @(posedge clk); while (rxr !== 1'b1);
        end else tq.push_back((cur[x] + 16'(i)) ^ 16'h5a5a);
      end
      rxv <= 1'b0;
      for (k = 0; k < 999 && tq.size() != 0; k++) @(posedge clk);
      w = 16'($urandom) & 16'hfdff;
      wq.push_back({inf[x], w | {6'h00, b & ext3, 9'h000}});
      wq.push_back({inf[x] + 16'h0001, ~w});
      mend <= 1'b1;
      merr <= er;
      minfo <= w;
      mtag <= ~w;
      if (!er && !(b && tr)) begin
        full = ((inf[x] + 16'h0001) & mask) == mask;
        nc = full ? sp[x] : cur[x] + 16'(n);
        ni = full ? inf[x] & ~mask : inf[x] + 16'h0002;
        wq.push_back({nd + 16'h0002, nc});
        wq.push_back({nd + 16'h0003, ni});
        pend = pend | (full & ctl[8] & ien);
        cur[x] = nc;
        inf[x] = ni;
      end
      do @(posedge clk); while (mer !== 1'b1);
      mend <= 1'b0;
    end
    for (k = 0; k < 999 && done !== 1'b1; k++) @(posedge clk);
    chk(done === 1'b1, "no done");
    @(posedge clk);
    chk(wq.size() == 0 && tq.size() == 0, "traffic missing");
    chk(int_n === !(pend & ien), "int level");
  endtask
  // ==========
  // scoreboard: oldest note against each result
  always @(posedge clk) begin
    if (mreq === 1'b1 && mwe === 1'b1 && ack === 1'b1) begin
      chk(wq.size() != 0 && wq[0] === {maddr, mwd}, "mem write");
      if (wq.size() != 0) void'(wq.pop_front());
    end
    if (txv === 1'b1 && txr === 1'b1) begin
      chk(tq.size() != 0 && tq[0] === txw, "tx word");
      if (tq.size() != 0) void'(tq.pop_front());
    end
  end
  always @(posedge clk) txr <= ($urandom_range(3) != 0);
  initial begin
    #400_000;
    error_cnt++;
    summarize();
  end
  // ==========
  // main sequence
  initial begin
    {rst_n, psel, pen, pwr, start, bc, rxv, mend, merr, slow} = '0;
    {paddr, pwd, cmdw, rxw, minfo, mtag, pend, ien, ext3} = '0;
    error_cnt = 0;
    checks = 0;
    void'($urandom(32'h1c52));
    for (k = 0; k < 65536; k++) ram_u.mem_ff[k] = 16'(k) ^ 16'h5a5a;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h180, 32'h0000_0000);
    chk(r === 32'h0000_0400 && e === 1'b0 && int_n === 1'b1, "reset state");
    apb(1'b0, 12'h3fe, 32'h0000_0000);
    chk(r === 32'h0000_0000 && e === 1'b1, "unmapped");
    apb(1'b1, 12'h048, 32'h0000_0001);
    apb(1'b1, 12'h134, 32'h0000_0008);
    apb(1'b1, 12'h05c, 32'h0000_0001);
    ien = 1'b1;
    ext3 = 1'b1;
    desc(7'h03, 16'h0122, 16'h2000, 16'h0a00);
    desc(7'h23, 16'h0132, 16'h3000, 16'h0e00);
    desc(7'h07, 16'h0082, 16'h4000, 16'h0f00);
    desc(7'h05, 16'h0126, 16'h5000, 16'h0c00);
    for (int j = 0; j < 3; j++) msg(1'b0, 5'h03, j == 0 ? 5'h00 : 5'($urandom), j == 2, 1'b0);
    msg(1'b0, 5'h03, 5'h02, 1'b0, 1'b1);
    apb(1'b1, 12'h024, 32'h0000_0001);
    pend = 1'b0;
    apb(1'b0, 12'h024, 32'h0000_0000);
    chk(r === 32'h0000_0000 && int_n === 1'b1, "pending clear");
    apb(1'b1, 12'h048, 32'h0000_0000);
    ien = 1'b0;
    for (int j = 0; j < 6; j++) begin
      slow <= j[0];
      msg(1'b1, 5'h03, 5'($urandom), j == 1, 1'b0);
    end
    apb(1'b0, 12'h024, 32'h0000_0000);
    chk(r === {31'h0, pend} && int_n === 1'b1, "masked pending");
    msg(1'b0, 5'h05, 5'h03, 1'b0, 1'b0);
    for (int j = 0; j < 129; j++) msg(1'b0, 5'h07, 5'h01, 1'b0, 1'b0);
    summarize();
  end
endmodule // testbench
